// ==== hdl/lhp_device.sv ====
// display end: host port decode, serial receiver, bus holder, display ram and refresh scan
// Functional notes
// - interface-select pin picks parallel or serial
// - bus-style pin picks 6800 or 8080 strobes
// - select and read/write decode four access kinds
// - respond only with both chip selects active
// - serial bits sampled on rising clock, msb first
// - select line sampled at each eighth edge
// - deselect resets serial shifter and counter
// - host never reads in serial mode
// - data writes buffered, committed without wait states
// - first data read returns stale holder
// - busy on top bit; commands refused while busy
// - host keeping cycle time need not poll
// - ram is nine pages by 132 columns
// - data byte bits run along common rows
// - page eight stores only bit zero
// - page changes only by page command
// - column increments per data read or write, stops at 83h
// - segment direction reverses column to output order
// - start line sets first scanned ram line
// - display modes act on output latch only
// - refresh reads independent of host accesses
`timescale 1ns/10ps
`include "lhp_regs.svh"
module lhp_device
  import lhp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  lhp_if.device bus,
  output logic [6:0] scan_com,
  output logic [7:0] scan_seg,
  output logic scan_pixel
);
  typedef struct packed {
    lhp_pins_t s1;
    lhp_pins_t s2;
    lhp_pins_t q;
    logic [7:0] db_out;
    logic db_oe;
    logic [7:0] holder;
    logic [6:0] sh;
    logic [2:0] bitcnt;
    logic pend_v;
    logic [8:0] pend;
    logic [3:0] page;
    logic [7:0] col;
    logic [5:0] start_line;
    logic [2:0] busy_cnt;
    logic disp_on;
    logic seg_rev;
    logic inv;
    logic all_on;
    logic [6:0] com;
    logic [7:0] seg;
    logic [6:0] com_out;
    logic [7:0] seg_out;
    logic pixel;
    logic we;
    logic [10:0] waddr;
    logic [7:0] wdata;
  } lhp_dev_st_t;

  lhp_dev_st_t st;
  lhp_dev_st_t next_st;
  logic [7:0] mem [0:`LHP_RAM_WORDS-1];
  logic f_in_ready;
  logic f_out_valid;
  logic [8:0] f_out_data;
  logic f_out_ready;
  lhp_pins_t raw;
  logic sel;
  logic rd_now;
  logic rd_was;
  logic wr_now;
  logic wr_was;
  logic busy;
  logic [10:0] haddr;
  logic [7:0] hdata;
  logic [6:0] line;
  logic [7:0] scol;
  logic [7:0] sdata;
  logic [7:0] cmd;

  function automatic logic active(lhp_pins_t p, logic want_rd);
    logic on;
    on = !p.cs_l && p.cs_h && p.ps;
    if (p.c86)
    begin
      active = on && p.rd && (p.wr == want_rd);
    end
    else
    begin
      active = on && !(want_rd ? p.rd : p.wr);
    end
  endfunction

  function automatic logic [7:0] next_col(logic [7:0] c);
    next_col = (c < `LHP_LAST_COL) ? c + 8'h01 : c;
  endfunction

  assign raw = '{cs_l: bus.chip_select_low, cs_h: bus.chip_select_high, dc: bus.data_command_select,
    rd: bus.rd_or_enable, wr: bus.wr_or_rw, ps: bus.interface_type_select, c86: bus.bus_style_select, db: bus.db};
  assign f_out_ready = st.busy_cnt == 3'h0;
  assign bus.db_d_out = st.db_out;
  assign bus.db_d_oe = st.db_oe;
  assign scan_com = st.com_out;
  assign scan_seg = st.seg_out;
  assign scan_pixel = st.pixel;

  // write-side pressure stalls the pending byte, never the host strobe
  lhp_fifo #(
    .WIDTH(`LHP_FIFO_WIDTH),
    .DEPTH(`LHP_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .in_valid(st.pend_v),
    .in_ready(f_in_ready),
    .in_data(st.pend),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  always_comb
  begin
    next_st = st;
    next_st.s1 = raw;
    next_st.s2 = st.s1;
    next_st.q = st.s2;
    next_st.we = 1'b0;
    cmd = f_out_data[7:0];
    sel = !st.s2.cs_l && st.s2.cs_h;
    rd_now = active(st.s2, 1'b1);
    rd_was = active(st.q, 1'b1);
    wr_now = active(st.s2, 1'b0);
    wr_was = active(st.q, 1'b0);
    busy = (st.busy_cnt != 3'h0) || f_out_valid || st.pend_v;
    haddr = 11'(st.page) * `LHP_COLS + 11'(st.col);
    // a column past the last one would alias into the next page, so it reads zero
    hdata = (st.col <= `LHP_LAST_COL && haddr < 11'(`LHP_RAM_WORDS)) ? mem[haddr] : 8'h00;
    if (st.pend_v && f_in_ready)
    begin
      next_st.pend_v = 1'b0;
    end
    if (rd_now && !rd_was)
    begin
      next_st.db_oe = 1'b1;
      next_st.db_out = st.s2.dc ? st.holder : {busy, st.seg_rev, !st.disp_on, 5'h00};
    end
    if (!sel || !rd_now)
    begin
      next_st.db_oe = 1'b0;
    end
    if (rd_was && !rd_now && sel && st.q.dc)
    begin
      next_st.holder = hdata;
      next_st.col = next_col(st.col);
    end
    if (wr_was && !wr_now && sel && (st.q.dc || !busy))
    begin
      next_st.pend_v = 1'b1;
      next_st.pend = {st.q.dc, st.q.db};
    end
    if (!sel || st.s2.ps)
    begin
      next_st.sh = 7'h00;
      next_st.bitcnt = 3'h0;
    end
    else if (st.s2.db[`LHP_SCL_BIT] && !st.q.db[`LHP_SCL_BIT])
    begin
      next_st.sh = {st.sh[5:0], st.s2.db[`LHP_SI_BIT]};
      next_st.bitcnt = st.bitcnt + 3'h1;
      if (st.bitcnt == 3'h7)
      begin
        next_st.bitcnt = 3'h0;
        if (st.s2.dc || !busy)
        begin
          next_st.pend_v = 1'b1;
          next_st.pend = {st.s2.dc, st.sh, st.s2.db[`LHP_SI_BIT]};
        end
      end
    end
    if (st.busy_cnt != 3'h0)
    begin
      next_st.busy_cnt = st.busy_cnt - 3'h1;
    end
    else if (f_out_valid && f_out_data[8])
    begin
      if (st.col <= `LHP_LAST_COL && st.page <= `LHP_IND_PAGE)
      begin
        next_st.we = 1'b1;
        next_st.waddr = haddr;
        next_st.wdata = (st.page == `LHP_IND_PAGE) ? {7'h00, cmd[0]} : cmd;
      end
      next_st.col = next_col(next_st.col);
    end
    else if (f_out_valid)
    begin
      next_st.busy_cnt = `LHP_BUSY_CYC;
      if (cmd[7:1] == `LHP_CMD_DISP)
      begin
        next_st.disp_on = cmd[0];
      end
      else if (cmd[7:1] == `LHP_CMD_SEG)
      begin
        next_st.seg_rev = cmd[0];
      end
      else if (cmd[7:1] == `LHP_CMD_ALL)
      begin
        next_st.all_on = cmd[0];
      end
      else if (cmd[7:1] == `LHP_CMD_INV)
      begin
        next_st.inv = cmd[0];
      end
      else if (cmd[7:6] == `LHP_CMD_LINE)
      begin
        next_st.start_line = cmd[5:0];
      end
      else if (cmd[7:4] == `LHP_CMD_PAGE && cmd[3:0] <= `LHP_IND_PAGE)
      begin
        next_st.page = cmd[3:0];
      end
      else if (cmd[7:4] == `LHP_CMD_COLH)
      begin
        next_st.col = {cmd[3:0], st.col[3:0]};
      end
      else if (cmd[7:4] == `LHP_CMD_COLL)
      begin
        next_st.col = {st.col[7:4], cmd[3:0]};
      end
    end
    // refresh walks its own read port, so host traffic never disturbs it
    line = st.com + {1'b0, st.start_line};
    if (line >= `LHP_LINES)
    begin
      line = line - `LHP_LINES;
    end
    scol = st.seg_rev ? `LHP_LAST_COL - st.seg : st.seg;
    sdata = mem[11'(line[6:3]) * `LHP_COLS + 11'(scol)];
    next_st.pixel = st.disp_on && (st.all_on || (sdata[line[2:0]] ^ st.inv));
    next_st.com_out = st.com;
    next_st.seg_out = st.seg;
    next_st.seg = (st.seg == `LHP_LAST_COL) ? 8'h00 : st.seg + 8'h01;
    if (st.seg == `LHP_LAST_COL)
    begin
      next_st.com = (st.com == `LHP_LAST_LINE) ? 7'h00 : st.com + 7'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ram contents are not cleared by reset
  always_ff @(posedge ref_clk)
  begin
    if (st.we)
    begin
      mem[st.waddr] <= st.wdata;
    end
  end
endmodule

// ==== hdl/lhp_fifo.sv ====
// parameterised first-in first-out buffer with valid/ready on both sides
`timescale 1ns/10ps
module lhp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } lhp_fifo_st_t;
  lhp_fifo_st_t st;
  lhp_fifo_st_t next_st;
  logic [WIDTH-1:0] mem [0:DEPTH-1];

  assign in_ready = !((st.wp[AW] != st.rp[AW]) && (st.wp[AW-1:0] == st.rp[AW-1:0]));
  assign out_valid = st.wp != st.rp;
  assign out_data = mem[st.rp[AW-1:0]];

  always_comb
  begin
    next_st = st;
    if (in_valid && in_ready)
    begin
      next_st.wp = st.wp + 1'b1;
    end
    if (out_valid && out_ready)
    begin
      next_st.rp = st.rp + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (in_valid && in_ready)
    begin
      mem[st.wp[AW-1:0]] <= in_data;
    end
  end
endmodule

// ==== hdl/lhp_host.sv ====
// processor end: drives parallel strobes or serial clock from one user request at a time
`timescale 1ns/10ps
`include "lhp_regs.svh"
module lhp_host
  import lhp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  lhp_if.host bus,
  input wire logic cfg_serial,
  input wire logic cfg_6800,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire lhp_kind_t cmd_kind,
  input wire logic [7:0] cmd_data,
  output logic rsp_valid,
  output logic [7:0] rsp_data
);
  typedef struct packed {
    lhp_hstate_t state;
    logic [7:0] s1;
    logic [7:0] s2;
    logic [4:0] cnt;
    logic [2:0] bitn;
    logic isrd;
    logic [7:0] data;
    logic rdy;
    logic rsp_v;
    logic [7:0] rsp;
    logic cs_l;
    logic cs_h;
    logic dc;
    logic rd;
    logic wr;
    logic ps;
    logic c86;
    logic [7:0] dout;
    logic [7:0] doe;
  } lhp_host_st_t;

  lhp_host_st_t st;
  lhp_host_st_t next_st;

  assign cmd_ready = st.rdy;
  assign rsp_valid = st.rsp_v;
  assign rsp_data = st.rsp;
  assign bus.interface_type_select = st.ps;
  assign bus.bus_style_select = st.c86;
  assign bus.chip_select_low = st.cs_l;
  assign bus.chip_select_high = st.cs_h;
  assign bus.data_command_select = st.dc;
  assign bus.rd_or_enable = st.rd;
  assign bus.wr_or_rw = st.wr;
  assign bus.db_h_out = st.dout;
  assign bus.db_h_oe = st.doe;

  always_comb
  begin
    next_st = st;
    next_st.s1 = bus.db;
    next_st.s2 = st.s1;
    next_st.rsp_v = 1'b0;
    next_st.cnt = st.cnt + 5'h01;
    case (st.state)
      H_IDLE:
      begin
        next_st.ps = !cfg_serial;
        next_st.c86 = cfg_6800;
        next_st.rd = !cfg_6800;
        next_st.wr = 1'b1;
        next_st.rdy = 1'b1;
        next_st.cnt = 5'h00;
        if (cmd_valid && st.rdy)
        begin
          next_st.isrd = cmd_kind[1];
          next_st.data = cmd_data;
          if (cfg_serial && cmd_kind[1])
          begin
            next_st.rsp_v = 1'b1;
            next_st.rsp = 8'h00;
          end
          else
          begin
            next_st.rdy = 1'b0;
            next_st.cs_l = 1'b0;
            next_st.cs_h = 1'b1;
            next_st.dc = !cmd_kind[0];
            next_st.bitn = 3'h0;
            if (cfg_serial)
            begin
              next_st.state = H_SCL_LO;
              next_st.doe = 8'hC0;
              next_st.dout = {cmd_data[7], 7'h00};
            end
            else
            begin
              next_st.state = H_SETUP;
              next_st.wr = cfg_6800 ? cmd_kind[1] : 1'b1;
              next_st.doe = cmd_kind[1] ? 8'h00 : 8'hFF;
              next_st.dout = cmd_data;
            end
          end
        end
      end
      H_SETUP:
      begin
        if (st.cnt == 5'(`LHP_SETUP_CYC - 1))
        begin
          next_st.cnt = 5'h00;
          next_st.state = H_STROBE;
          next_st.rd = st.c86 ? 1'b1 : !st.isrd;
          next_st.wr = st.c86 ? st.wr : st.isrd;
        end
      end
      H_STROBE:
      begin
        if (st.cnt == 5'(`LHP_STROBE_CYC - 1))
        begin
          next_st.cnt = 5'h00;
          next_st.state = H_HOLD;
          next_st.rsp = st.s2;
          next_st.rd = !st.c86;
          next_st.wr = st.c86 ? st.wr : 1'b1;
        end
      end
      H_HOLD:
      begin
        if (st.cnt == 5'(`LHP_HOLD_CYC - 1))
        begin
          next_st.cnt = 5'h00;
          next_st.state = H_DONE;
          next_st.cs_l = 1'b1;
          next_st.cs_h = 1'b0;
          next_st.doe = 8'h00;
          next_st.wr = 1'b1;
          next_st.rsp_v = st.isrd;
        end
      end
      H_DONE:
      begin
        // fixed recovery keeps the cycle time, so busy is never polled
        if (st.cnt == 5'(`LHP_RECOVER_CYC - 1))
        begin
          next_st.state = H_IDLE;
          next_st.rdy = 1'b1;
        end
      end
      H_SCL_LO:
      begin
        if (st.cnt == 5'(`LHP_SCL_HALF_CYC - 1))
        begin
          next_st.cnt = 5'h00;
          next_st.state = H_SCL_HI;
          next_st.dout[`LHP_SCL_BIT] = 1'b1;
        end
      end
      H_SCL_HI:
      begin
        if (st.cnt == 5'(`LHP_SCL_HALF_CYC - 1))
        begin
          next_st.cnt = 5'h00;
          next_st.dout[`LHP_SCL_BIT] = 1'b0;
          next_st.data = {st.data[6:0], 1'b0};
          next_st.dout[`LHP_SI_BIT] = st.data[6];
          next_st.bitn = st.bitn + 3'h1;
          next_st.state = (st.bitn == 3'h7) ? H_HOLD : H_SCL_LO;
        end
      end
      default:
      begin
        next_st.state = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st <= '{state: H_IDLE, cs_l: 1'b1, rd: 1'b1, wr: 1'b1, ps: 1'b1, default: '0};
    end
    else
    begin
      st <= next_st;
    end
  end
endmodule

// ==== hdl/lhp_if.sv ====
// pin-level carrier between processor end and display end
`timescale 1ns/10ps
interface lhp_if;
  logic interface_type_select;
  logic bus_style_select;
  logic chip_select_low;
  logic chip_select_high;
  logic data_command_select;
  logic rd_or_enable;
  logic wr_or_rw;
  logic [7:0] db_h_out;
  logic [7:0] db_h_oe;
  logic [7:0] db_d_out;
  logic db_d_oe;
  logic [7:0] db;
  // undriven bits read high, as through a pull-up
  assign db = (db_h_oe & db_h_out) | (~db_h_oe & (db_d_oe ? db_d_out : 8'hFF));
  modport host (output interface_type_select, bus_style_select, chip_select_low, chip_select_high,
    data_command_select, rd_or_enable, wr_or_rw, db_h_out, db_h_oe, input db);
  modport device (input interface_type_select, bus_style_select, chip_select_low, chip_select_high,
    data_command_select, rd_or_enable, wr_or_rw, db, output db_d_out, db_d_oe);
endinterface

// ==== hdl/lhp_pkg.sv ====
// types shared by both ends of the display host port
package lhp_pkg;
  typedef struct packed {
    logic cs_l;
    logic cs_h;
    logic dc;
    logic rd;
    logic wr;
    logic ps;
    logic c86;
    logic [7:0] db;
  } lhp_pins_t;
  typedef enum logic [1:0] {LHP_DATA_WR, LHP_CMD_WR, LHP_DATA_RD, LHP_STAT_RD} lhp_kind_t;
  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_STROBE, H_HOLD, H_DONE, H_SCL_LO, H_SCL_HI} lhp_hstate_t;
endpackage

// ==== hdl/lhp_regs.svh ====
// timing counts, command codes and field positions of the display host port
`ifndef LHP_REGS_SVH
`define LHP_REGS_SVH
`define LHP_CLK_MHZ 100
`define LHP_NS2CYC(ns) ((((ns) * `LHP_CLK_MHZ) + 999) / 1000)
`define LHP_T_SETUP_NS 20
`define LHP_T_STROBE_NS 120
`define LHP_T_HOLD_NS 30
`define LHP_T_RECOVER_NS 200
`define LHP_T_SCL_HALF_NS 80
`define LHP_SETUP_CYC `LHP_NS2CYC(`LHP_T_SETUP_NS)
`define LHP_STROBE_CYC `LHP_NS2CYC(`LHP_T_STROBE_NS)
`define LHP_HOLD_CYC `LHP_NS2CYC(`LHP_T_HOLD_NS)
`define LHP_RECOVER_CYC `LHP_NS2CYC(`LHP_T_RECOVER_NS)
`define LHP_SCL_HALF_CYC `LHP_NS2CYC(`LHP_T_SCL_HALF_NS)
`define LHP_BUSY_CYC 3'h4
`define LHP_COLS 11'h084
`define LHP_LAST_COL 8'h83
`define LHP_LAST_LINE 7'h40
`define LHP_LINES 7'h41
`define LHP_IND_PAGE 4'h8
`define LHP_RAM_WORDS 1188
`define LHP_FIFO_DEPTH 32
`define LHP_FIFO_WIDTH 9
`define LHP_CMD_DISP 7'h57
`define LHP_CMD_SEG 7'h50
`define LHP_CMD_ALL 7'h52
`define LHP_CMD_INV 7'h53
`define LHP_CMD_LINE 2'h1
`define LHP_CMD_PAGE 4'hB
`define LHP_CMD_COLH 4'h1
`define LHP_CMD_COLL 4'h0
`define LHP_ST_BUSY 7
`define LHP_ST_SEG 6
`define LHP_ST_OFF 5
`define LHP_SI_BIT 7
`define LHP_SCL_BIT 6
`endif

// ==== sim/lcd_host_port_and_ram_addressing_tb_top.sv ====
// end-to-end bench: processor end drives display end over the pin carrier
`timescale 1ns/10ps
module lcd_host_port_and_ram_addressing_tb_top import lhp_pkg::*;;
  logic ref_clk, nrst, cfg_serial, cfg_6800, cmd_valid, cmd_ready, rsp_valid, scan_pixel;
  lhp_kind_t cmd_kind;
  logic [7:0] cmd_data, rsp_data, rd, col, hold, hmask, scan_seg;
  logic [6:0] scan_com;
  logic [3:0] page, pg;
  logic hold_ok, seg_rev, disp_off;
  logic [7:0] mem [0:8][0:131];
  logic [6:0] tcom;
  logic [7:0] tseg;
  logic [5:0] sl;
  logic [2:0] b;
  logic [7:0] seq[$];
  int mismatches, n_compared, seed, m, i;
  lhp_if bus_if();
  lhp_host lhp_host_i(.ref_clk, .nrst, .bus(bus_if), .cfg_serial, .cfg_6800, .cmd_valid, .cmd_ready,
    .cmd_kind, .cmd_data, .rsp_valid, .rsp_data);
  lhp_device lhp_device_i(.ref_clk, .nrst, .bus(bus_if), .scan_com, .scan_seg, .scan_pixel);
  lhp_chk_sva lhp_chk_sva_i(.ref_clk, .nrst, .interface_type_select(bus_if.interface_type_select),
    .bus_style_select(bus_if.bus_style_select), .chip_select_low(bus_if.chip_select_low),
    .chip_select_high(bus_if.chip_select_high), .rd_or_enable(bus_if.rd_or_enable),
    .wr_or_rw(bus_if.wr_or_rw), .db_h_out(bus_if.db_h_out), .db_h_oe(bus_if.db_h_oe), .db_d_oe(bus_if.db_d_oe));
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [7:0] exp_status();
    return {1'b0, seg_rev, disp_off, 5'h00};
  endfunction
  function automatic logic [7:0] next_col(input logic [7:0] c);
    return (c < 8'h83) ? c + 8'h01 : c;
  endfunction
  // one host request; also advances the expected page, column and holder
  task automatic op(input lhp_kind_t k, input logic [7:0] d);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 400)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 400) check("cmd_ready", 9'h001, 9'h000);
    cmd_kind = k;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(posedge ref_clk);
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    rd = 8'h00;
    if (k inside {LHP_DATA_RD, LHP_STAT_RD})
    begin
      n = 0;
      while (rsp_valid !== 1'b1 && n < 40)
      begin
        @(negedge ref_clk);
        n++;
      end
      if (n >= 40) check("rsp_valid", 9'h001, 9'h000);
      rd = rsp_data;
    end
    if (cfg_serial && k inside {LHP_DATA_RD, LHP_STAT_RD})
      check("serial read", 8'h00, rd);
    else
    case (k)
      LHP_CMD_WR:
      begin
        hold_ok = 1'b0;
        if (d[7:4] == 4'hB && d[3:0] <= 4'h8) page = d[3:0];
        if (d[7:4] == 4'h1) col[7:4] = d[3:0];
        if (d[7:4] == 4'h0) col[3:0] = d[3:0];
        if (d inside {8'hA0, 8'hA1}) seg_rev = d[0];
        if (d inside {8'hAE, 8'hAF}) disp_off = !d[0];
      end
      LHP_DATA_WR:
      begin
        hold_ok = 1'b0;
        if (col <= 8'h83) mem[page][col] = (page == 4'h8) ? {7'h00, d[0]} : d;
        col = next_col(col);
      end
      LHP_DATA_RD:
      begin
        if (hold_ok) check("data read", hold & hmask, rd & hmask);
        hold = (col <= 8'h83) ? mem[page][col] : 8'h00;
        hmask = (page == 4'h8) ? 8'h01 : 8'hFF;
        hold_ok = 1'b1;
        col = next_col(col);
      end
      default: check("status", exp_status(), rd);
    endcase
  endtask
  // let the last command settle, then wait for the scan to reach the watched pixel
  task automatic scan_check(input string what, input logic exp);
    int n;
    n = 0;
    repeat (40) @(negedge ref_clk);
    while ((scan_com !== tcom || scan_seg !== tseg) && n < 9000)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 9000) check("scan position", 9'h001, 9'h000);
    check(what, {8'h00, exp}, {8'h00, scan_pixel});
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    // about 45k cycles expected; the four full-frame scan waits dominate
    #700000;
    mismatches++;
    close_out();
  end
  initial
  begin
    seed = 32'h9DDD;
    {nrst, cfg_serial, cfg_6800, cmd_valid} = '0;
    cmd_kind = LHP_DATA_WR;
    {cmd_data, page, col, hold, hold_ok, seg_rev} = '0;
    {hmask, disp_off} = {8'hFF, 1'b1};
    repeat (6) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (3) @(negedge ref_clk);
    // modes 8080, 6800, serial; serial data is read back over 8080
    for (m = 0; m < 3; m++)
    begin
      cfg_6800 = (m == 1);
      cfg_serial = (m == 2);
      pg = (m == 0) ? 4'h8 : {1'b0, 3'($random(seed))};
      op(LHP_CMD_WR, {4'hB, pg});
      op(LHP_CMD_WR, 8'h18);
      op(LHP_CMD_WR, 8'h02);
      for (i = 0; i < 4; i++) op(LHP_DATA_WR, 8'($random(seed)));
      op(LHP_CMD_WR, 8'h13);
      op(LHP_CMD_WR, 8'h0E);
      for (i = 0; i < 5; i++) op(LHP_DATA_WR, 8'($random(seed)));
      op(LHP_STAT_RD, 8'h00);
      cfg_serial = 1'b0;
      // display settings must leave stored data alone
      seq = {8'hA1, 8'hA5, 8'hA7, 8'hAF, 8'h40 | 8'($random(seed) & 63)};
      foreach (seq[j]) op(LHP_CMD_WR, seq[j]);
      op(LHP_STAT_RD, 8'h00);
      op(LHP_CMD_WR, 8'h18);
      op(LHP_CMD_WR, 8'h02);
      repeat (3) op(LHP_DATA_RD, 8'h00);
      op(LHP_CMD_WR, 8'h13);
      op(LHP_CMD_WR, 8'h0E);
      repeat (6) op(LHP_DATA_RD, 8'h00);
      seq = {8'hA0, 8'hA4, 8'hA6, 8'hAE};
      foreach (seq[j]) op(LHP_CMD_WR, seq[j]);
      op(LHP_STAT_RD, 8'h00);
      $display("test mode %0d done", m);
    end
    // a burst longer than the write buffer, read back in order through the display end
    op(LHP_CMD_WR, 8'h10);
    op(LHP_CMD_WR, 8'h00);
    for (i = 0; i < 34; i++) op(LHP_DATA_WR, 8'($random(seed)));
    op(LHP_CMD_WR, 8'h10);
    op(LHP_CMD_WR, 8'h00);
    repeat (35) op(LHP_DATA_RD, 8'h00);
    op(LHP_STAT_RD, 8'h00);
    $display("test burst done");
    // one written pixel watched through reversed columns and a random start line
    sl = 6'($random(seed));
    b = 3'($random(seed));
    tcom = 7'((65 + {pg[2:0], b} - sl) % 65);
    tseg = 8'h83 - 8'h3E;
    op(LHP_CMD_WR, 8'hAF);
    op(LHP_CMD_WR, 8'hA1);
    op(LHP_CMD_WR, {2'b01, sl});
    scan_check("scan_pixel normal", mem[pg][8'h3E][b]);
    op(LHP_CMD_WR, 8'hA7);
    scan_check("scan_pixel inverse", !mem[pg][8'h3E][b]);
    op(LHP_CMD_WR, 8'hA5);
    scan_check("scan_pixel all on", 1'b1);
    op(LHP_CMD_WR, 8'hAE);
    scan_check("scan_pixel off", 1'b0);
    $display("test scan done");
    close_out();
  end
endmodule

// ==== sim/lhp_chk_sva.sv ====
// pin-level checks on the link between processor end and display end
`timescale 1ns/10ps
module lhp_chk_sva (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic interface_type_select,
  input wire logic bus_style_select,
  input wire logic chip_select_low,
  input wire logic chip_select_high,
  input wire logic rd_or_enable,
  input wire logic wr_or_rw,
  input wire logic [7:0] db_h_out,
  input wire logic [7:0] db_h_oe,
  input wire logic db_d_oe
);
  wire sel = !chip_select_low && chip_select_high;
  wire par = sel && interface_type_select;
  wire ser = sel && !interface_type_select;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  // sync lag of the device allows a few cycles before release
  chk_float_when_deselected: assert property ((!sel)[*4] |-> !db_d_oe)
    else $error("device drives bus while deselected");
  chk_serial_never_drives: assert property ((!interface_type_select)[*4] |-> !db_d_oe)
    else $error("device drives bus in serial mode");
  chk_serial_pin_use: assert property (ser |-> db_h_oe == 8'hC0)
    else $error("serial mode drives more than data and clock");
  chk_scl_high_time: assert property ($rose(db_h_out[6]) && ser |-> db_h_out[6][*8])
    else $error("serial clock high phase too short");
  chk_si_stable_high: assert property (ser && db_h_out[6] && $past(db_h_out[6]) |-> $stable(db_h_out[7]))
    else $error("serial data moved while clock high");
  chk_read_answer_8080: assert property ($fell(rd_or_enable) && par && !bus_style_select |-> ##[2:6] db_d_oe)
    else $error("no read drive after 8080 read strobe");
  chk_read_answer_6800: assert property ($rose(rd_or_enable) && wr_or_rw && par && bus_style_select
    |-> ##[2:6] db_d_oe)
    else $error("no read drive after 6800 enable");
  chk_drive_decode: assert property ($rose(db_d_oe) |-> par && (bus_style_select ? (rd_or_enable && wr_or_rw)
    : !rd_or_enable))
    else $error("read drive without a read access");
  chk_write_strobe: assert property ($fell(wr_or_rw) && par && !bus_style_select
    |-> (!wr_or_rw && db_h_oe == 8'hFF)[*8])
    else $error("8080 write strobe or data too short");
  cover property ($rose(db_d_oe) && bus_style_select);
  cover property ($rose(db_d_oe) && !bus_style_select);
  cover property (ser && $rose(db_h_out[6]));
endmodule
